/* File: mou_core.sv */
// Purpose: Memory operation unit: transmit-buffer move, block copy, block XOR.
// Assumes: Memory answers a read with data in the same cycle as the request.
// Notes: High priority is served before low when both wait; one runs at a time.
`timescale 1ns/1ns
`default_nettype none
module mou_core (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Instruction issue
   input wire logic issue_in,
   input wire mou_pkg::instr_s instr_in,
   // Memory port
   output logic mem_rd_out,
   output logic mem_wr_out,
   output logic [mou_pkg::ADDR_W-1:0] mem_addr_out,
   output logic [7:0] mem_wdata_out,
   input wire logic [7:0] mem_rdata_in,
   // Transmit buffer port
   output logic transmit_buffer_wr_out,
   output logic [7:0] transmit_buffer_data_out,
   input wire logic transmit_buffer_full_in,
   // Exceptions and status
   output mou_pkg::exc_s exc_out,
   output logic [mou_pkg::CNT_W-1:0] remaining_out,
   output logic busy_low_out,
   output logic busy_high_out
);
   import mou_pkg::*;

   logic [1:0] busy;
   logic [1:0] accept;
   logic [1:0] finish;
   instr_s slot_instr [2];
   st_e st_q;
   logic cur_prio_q;
   instr_s cur;
   logic [CNT_W-1:0] left_q;
   logic [ADDR_W-1:0] ptr_a_q;
   logic [ADDR_W-1:0] ptr_e_q;
   logic [7:0] byte_a_q;
   logic misuse_d;
   logic ovf_q;

   // A busy level refuses the new instruction, which never reaches its slot.
   always_comb begin
      misuse_d = issue_in && busy[instr_in.prio];
      accept[PRIO_LOW] = issue_in && !busy[PRIO_LOW] && instr_in.prio == PRIO_LOW;
      accept[PRIO_HIGH] = issue_in && !busy[PRIO_HIGH] && instr_in.prio == PRIO_HIGH;
   end

   for (genvar i = 0; i < 2; i++) begin : g_slot
      mou_slot u_slot (
         .clk_in(clk_in),
         .rst_n_in(rst_n_in),
         .accept_in(accept[i]),
         .instr_in(instr_in),
         .finish_in(finish[i]),
         .busy_out(busy[i]),
         .instr_out(slot_instr[i])
      );
   end

   assign cur = slot_instr[cur_prio_q];
   assign finish[PRIO_LOW] = st_q == ST_DONE && cur_prio_q == PRIO_LOW;
   assign finish[PRIO_HIGH] = st_q == ST_DONE && cur_prio_q == PRIO_HIGH;

   // A slot accepted this cycle is only picked up next cycle, once registered.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_q <= ST_IDLE;
         cur_prio_q <= PRIO_LOW;
         left_q <= CNT_RST;
         ptr_a_q <= ADDR_RST;
         ptr_e_q <= ADDR_RST;
         ovf_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (busy[PRIO_HIGH] || busy[PRIO_LOW]) begin
                  cur_prio_q <= busy[PRIO_HIGH] ? PRIO_HIGH : PRIO_LOW;
                  left_q <= busy[PRIO_HIGH] ? slot_instr[PRIO_HIGH].count
                                            : slot_instr[PRIO_LOW].count;
                  ptr_a_q <= busy[PRIO_HIGH] ? slot_instr[PRIO_HIGH].addr_a
                                             : slot_instr[PRIO_LOW].addr_a;
                  ptr_e_q <= busy[PRIO_HIGH] ? slot_instr[PRIO_HIGH].addr_e
                                             : slot_instr[PRIO_LOW].addr_e;
                  ovf_q <= 1'b0;
                  st_q <= ST_READ_A;
               end
            end
            ST_READ_A: begin
               if (left_q == CNT_RST) begin
                  st_q <= ST_DONE;
               end else if (cur.op == OP_TXMOVE && transmit_buffer_wr_out) begin
                  // The byte in flight is not yet in the fill level, so judging full now
                  // would let one byte too many into the buffer.
                  st_q <= ST_READ_A;
               end else if (cur.op == OP_TXMOVE && transmit_buffer_full_in) begin
                  ovf_q <= 1'b1;
                  st_q <= ST_DONE;
               end else begin
                  st_q <= cur.op == OP_XOR ? ST_READ_E : ST_WRITE;
               end
            end
            ST_READ_E: st_q <= ST_WRITE;
            ST_WRITE: begin
               left_q <= left_q - 8'h01;
               ptr_a_q <= ptr_a_q + 12'h001;
               ptr_e_q <= ptr_e_q + 12'h001;
               st_q <= ST_READ_A;
            end
            ST_DONE: st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Capture byte A the cycle after it was requested.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         byte_a_q <= DATA_RST;
      end else if (st_q == ST_READ_E || (st_q == ST_WRITE && cur.op != OP_XOR)) begin
         byte_a_q <= mem_rdata_in;
      end
   end

   // Memory and transmit-buffer strobes are registered from current-state intent.
   logic rd_d;
   logic wr_d;
   logic tx_d;
   logic [ADDR_W-1:0] addr_d;
   logic [7:0] wdata_d;
   logic go_a;
   assign go_a = st_q == ST_READ_A && left_q != CNT_RST
                 && !(cur.op == OP_TXMOVE && (transmit_buffer_full_in || transmit_buffer_wr_out));
   always_comb begin
      rd_d = 1'b0;
      wr_d = 1'b0;
      tx_d = 1'b0;
      addr_d = ptr_a_q;
      wdata_d = DATA_RST;
      if (go_a) begin
         rd_d = 1'b1;
      end else if (st_q == ST_READ_E) begin
         rd_d = 1'b1;
         addr_d = ptr_e_q;
      end else if (st_q == ST_WRITE) begin
         if (cur.op == OP_TXMOVE) begin
            tx_d = 1'b1;
         end else begin
            wr_d = 1'b1;
            addr_d = ptr_e_q;
            wdata_d = cur.op == OP_XOR ? (byte_a_q ^ mem_rdata_in) : mem_rdata_in;
         end
      end
   end

   // Strobes lag intent by one cycle, so byte A for transmit-buffer move is read here directly.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mem_rd_out <= 1'b0;
         mem_wr_out <= 1'b0;
         mem_addr_out <= ADDR_RST;
         mem_wdata_out <= DATA_RST;
         transmit_buffer_wr_out <= 1'b0;
         transmit_buffer_data_out <= DATA_RST;
      end else begin
         mem_rd_out <= rd_d;
         mem_wr_out <= wr_d;
         mem_addr_out <= addr_d;
         mem_wdata_out <= wdata_d;
         transmit_buffer_wr_out <= tx_d;
         transmit_buffer_data_out <= mem_rdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         exc_out <= '0;
         remaining_out <= CNT_RST;
         busy_low_out <= 1'b0;
         busy_high_out <= 1'b0;
      end else begin
         exc_out.misuse <= misuse_d;
         exc_out.done_low <= finish[PRIO_LOW];
         exc_out.done_high <= finish[PRIO_HIGH];
         exc_out.tx_overflow <= st_q == ST_DONE && ovf_q;
         if (st_q == ST_DONE && ovf_q) begin
            remaining_out <= left_q;
         end
         busy_low_out <= busy[PRIO_LOW];
         busy_high_out <= busy[PRIO_HIGH];
      end
   end

   property p_misuse;
      @(posedge clk_in) disable iff (!rst_n_in)
      issue_in && busy[instr_in.prio] |=> exc_out.misuse;
   endproperty
   a_misuse: assert property (p_misuse) else $error("misuse not raised");

   property p_done;
      @(posedge clk_in) disable iff (!rst_n_in)
      st_q == ST_DONE |=> (exc_out.done_low ^ exc_out.done_high);
   endproperty
   a_done: assert property (p_done) else $error("done not raised");

   property p_ovf_done;
      @(posedge clk_in) disable iff (!rst_n_in)
      exc_out.tx_overflow |-> (exc_out.done_low || exc_out.done_high);
   endproperty
   a_ovf_done: assert property (p_ovf_done) else $error("overflow without done");

   property p_ovf_rem;
      @(posedge clk_in) disable iff (!rst_n_in)
      st_q == ST_DONE && ovf_q |=> remaining_out == $past(left_q);
   endproperty
   a_ovf_rem: assert property (p_ovf_rem) else $error("remaining count wrong");

   property p_tx_space;
      @(posedge clk_in) disable iff (!rst_n_in)
      transmit_buffer_wr_out |-> !transmit_buffer_full_in;
   endproperty
   a_tx_space: assert property (p_tx_space) else $error("byte sent into full buffer");

   property p_accept_busy;
      @(posedge clk_in) disable iff (!rst_n_in)
      issue_in && !busy[instr_in.prio] |=> busy[$past(instr_in.prio)] && !exc_out.misuse;
   endproperty
   a_accept_busy: assert property (p_accept_busy) else $error("accept failed");

   property p_copy_data;
      @(posedge clk_in) disable iff (!rst_n_in)
      st_q == ST_WRITE && cur.op == OP_COPY |=> mem_wr_out && mem_wdata_out == $past(mem_rdata_in);
   endproperty
   a_copy_data: assert property (p_copy_data) else $error("copy data wrong");

   property p_xor_data;
      @(posedge clk_in) disable iff (!rst_n_in)
      st_q == ST_WRITE && cur.op == OP_XOR
      |=> mem_wr_out && mem_wdata_out == ($past(byte_a_q) ^ $past(mem_rdata_in));
   endproperty
   a_xor_data: assert property (p_xor_data) else $error("xor data wrong");

   property p_xor_dest;
      @(posedge clk_in) disable iff (!rst_n_in)
      st_q == ST_WRITE && cur.op != OP_TXMOVE |=> mem_addr_out == $past(ptr_e_q);
   endproperty
   a_xor_dest: assert property (p_xor_dest) else $error("write address wrong");

   property p_prio;
      @(posedge clk_in) disable iff (!rst_n_in)
      st_q == ST_IDLE && busy[PRIO_HIGH] |=> cur_prio_q == PRIO_HIGH;
   endproperty
   a_prio: assert property (p_prio) else $error("priority order wrong");
endmodule : mou_core
`default_nettype wire

/* File: mou_pkg.sv */
// Purpose: Shared types and constants for the memory operation unit.
// Assumes: One clock, synchronous active-low reset.
// Notes: Addresses are 12 bits, byte counts 8 bits.
`default_nettype none
package mou_pkg;
   localparam int ADDR_W = 12;
   localparam int CNT_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic PRIO_LOW = 1'b0;
   localparam logic PRIO_HIGH = 1'b1;

   typedef enum logic [1:0] {
      OP_TXMOVE = 2'b00,
      OP_COPY = 2'b01,
      OP_XOR = 2'b10
   } op_e;

   typedef struct packed {
      op_e op;
      logic prio;
      logic [CNT_W-1:0] count;
      logic [ADDR_W-1:0] addr_a;
      logic [ADDR_W-1:0] addr_e;
   } instr_s;

   typedef struct packed {
      logic misuse;
      logic done_low;
      logic done_high;
      logic tx_overflow;
   } exc_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ_A = 3'b001,
      ST_READ_E = 3'b010,
      ST_WRITE = 3'b011,
      ST_DONE = 3'b100
   } st_e;
endpackage : mou_pkg
`default_nettype wire

/* File: mou_slot.sv */
// Purpose: Holds one priority level's instruction and its busy state.
// Assumes: Accept and finish are one-cycle pulses from the same clock.
// Notes: A finish and a new accept in one cycle leave the slot busy.
`timescale 1ns/1ns
`default_nettype none
module mou_slot (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic accept_in,
   input wire mou_pkg::instr_s instr_in,
   input wire logic finish_in,
   // State
   output logic busy_out,
   output mou_pkg::instr_s instr_out
);
   import mou_pkg::*;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         busy_out <= 1'b0;
      end else if (accept_in) begin
         busy_out <= 1'b1;
      end else if (finish_in) begin
         busy_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         instr_out <= '0;
      end else if (accept_in) begin
         instr_out <= instr_in;
      end
   end
endmodule : mou_slot
`default_nettype wire

/* File: mem_model.sv */
// Purpose: Memory and transmit buffer that stand on the far side of the unit.
// Assumes: Read data is valid in the cycle that the read strobe is high.
// Notes: Idle read data is the inverse of the last byte, so stale data never looks valid.
`timescale 1ns/1ns
`default_nettype none
module mem_model (
   // Clock
   input wire logic clk_in,
   // Memory
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic [mou_pkg::ADDR_W-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   // Transmit buffer
   input wire logic tx_wr_in,
   input wire logic [7:0] tx_data_in,
   input wire logic [7:0] tx_space_in,
   output logic tx_full_out
);
   logic [7:0] mem [0:4095];
   logic [7:0] tx_buf [0:255];
   logic [7:0] tx_cnt_q;
   logic [7:0] last_q;
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
      tx_cnt_q = 8'h00;
      last_q = 8'h00;
   end
   assign rdata_out = rd_in ? mem[addr_in] : ~last_q;
   assign tx_full_out = (tx_cnt_q >= tx_space_in);
   always @(posedge clk_in) begin
      if (rd_in) last_q <= mem[addr_in];
      if (wr_in) mem[addr_in] <= wdata_in;
      if (tx_wr_in) begin
         tx_buf[tx_cnt_q] <= tx_data_in;
         tx_cnt_q <= tx_cnt_q + 8'h01;
      end
   end
endmodule : mem_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the memory operation unit.
// Assumes: Exception pulses stand one cycle and are collected at every edge.
// Notes: Each scenario uses its own memory region so expectations stay independent.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mou_pkg::*;
   logic clk_in, rst_n_in, issue_in, mem_rd, mem_wr, tx_wr, tx_full, busy_low, busy_high;
   instr_s instr_in;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata, tx_data, tx_space;
   logic [CNT_W-1:0] remaining;
   exc_s exc;
   exc_s seen;
   int num_errors = 0;
   int comparisons = 0;
   mou_core uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .issue_in(issue_in),
      .instr_in(instr_in), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr),
      .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
      .transmit_buffer_wr_out(tx_wr), .transmit_buffer_data_out(tx_data), .transmit_buffer_full_in(tx_full),
      .exc_out(exc), .remaining_out(remaining), .busy_low_out(busy_low),
      .busy_high_out(busy_high));
   mem_model mem_i (.clk_in(clk_in), .rd_in(mem_rd), .wr_in(mem_wr), .addr_in(mem_addr),
      .wdata_in(mem_wdata), .rdata_out(mem_rdata), .tx_wr_in(tx_wr),
      .tx_data_in(tx_data), .tx_space_in(tx_space), .tx_full_out(tx_full));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   function automatic logic [7:0] pat(int a);
      return 8'(a) ^ 8'h5A;
   endfunction : pat
   task automatic report_and_stop();
      $display("Errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("Error: %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : chk
   // Pulses are read just after the edge that launches them, so each is caught exactly once.
   task automatic step();
      @(posedge clk_in);
      #1;
      seen = seen | exc;
   endtask : step
   task automatic issue(op_e op, logic prio, logic [7:0] cnt, logic [11:0] a, logic [11:0] e);
      issue_in = 1'b1;
      instr_in = '{op, prio, cnt, a, e};
      step();
      issue_in = 1'b0;
      // One idle edge keeps a following issue from raising the strobe in this time step.
      step();
   endtask : issue
   task automatic wait_done(logic prio);
      int n;
      n = 0;
      while ((prio ? seen.done_high : seen.done_low) !== 1'b1 && n < 400) begin
         step();
         n++;
      end
      if ((prio ? seen.done_high : seen.done_low) !== 1'b1) begin
         $display("Error: done wait expected 1 seen timeout");
         num_errors++;
         report_and_stop();
      end
   endtask : wait_done
   task automatic sc_copy();
      seen = '0;
      issue(OP_COPY, PRIO_LOW, 8'h04, 12'h010, 12'h100);
      wait_done(PRIO_LOW);
      for (int i = 0; i < 4; i++) chk("copy byte", pat(12'h010 + i), mem_i.mem[12'h100 + i]);
      chk("copy no dest overrun", pat(12'h104), mem_i.mem[12'h104]);
      chk("copy done high", 8'h00, 8'(seen.done_high));
   endtask : sc_copy
   task automatic sc_xor();
      seen = '0;
      issue(OP_XOR, PRIO_HIGH, 8'h03, 12'h020, 12'h200);
      wait_done(PRIO_HIGH);
      for (int i = 0; i < 3; i++)
         chk("xor byte", pat(12'h020 + i) ^ pat(12'h200 + i), mem_i.mem[12'h200 + i]);
      chk("xor src kept", pat(12'h020), mem_i.mem[12'h020]);
      chk("xor done low", 8'h00, 8'(seen.done_low));
   endtask : sc_xor
   task automatic sc_misuse();
      seen = '0;
      issue(OP_COPY, PRIO_LOW, 8'h08, 12'h030, 12'h300);
      issue(OP_COPY, PRIO_LOW, 8'h02, 12'h040, 12'h400);
      issue(OP_XOR, PRIO_HIGH, 8'h02, 12'h050, 12'h500);
      step();
      chk("misuse", 8'h01, 8'(seen.misuse));
      chk("busy both", 8'h03, {6'h00, busy_high, busy_low});
      wait_done(PRIO_LOW);
      wait_done(PRIO_HIGH);
      chk("dropped copy", pat(12'h400), mem_i.mem[12'h400]);
      chk("low last byte", pat(12'h037), mem_i.mem[12'h307]);
      chk("high xor", pat(12'h051) ^ pat(12'h501), mem_i.mem[12'h501]);
   endtask : sc_misuse
   task automatic sc_tx();
      seen = '0;
      tx_space = 8'h02;
      issue(OP_TXMOVE, PRIO_LOW, 8'h05, 12'h060, 12'h000);
      wait_done(PRIO_LOW);
      chk("overflow", 8'h01, 8'(seen.tx_overflow));
      chk("remaining", 8'h03, remaining);
      chk("tx byte 0", pat(12'h060), mem_i.tx_buf[0]);
      chk("tx byte 1", pat(12'h061), mem_i.tx_buf[1]);
      chk("tx count", 8'h02, mem_i.tx_cnt_q);
   endtask : sc_tx
   task automatic sc_zero();
      seen = '0;
      issue(OP_COPY, PRIO_HIGH, 8'h00, 12'h070, 12'h700);
      wait_done(PRIO_HIGH);
      chk("zero count dest", pat(12'h700), mem_i.mem[12'h700]);
      chk("zero count misuse", 8'h00, 8'(seen.misuse));
   endtask : sc_zero
   initial begin
      rst_n_in = 1'b0;
      issue_in = 1'b0;
      instr_in = '0;
      tx_space = 8'hFF;
      seen = '0;
      repeat (16) step();
      rst_n_in = 1'b1;
      sc_copy();
      sc_xor();
      sc_misuse();
      sc_tx();
      sc_zero();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
